// ### shared/hbs_pkg.sv
/*
 Constants for the host bus slave and remote port block.
 Assumes a single bus-side clock at 10 MHz and a synchronous active-low reset.
*/
package hbs_pkg;
   // ************************************************
   // Widths and register map
   // ************************************************
   localparam int REG_SEL_W = 4;
   localparam int DATA_W = 8;
   localparam int NUM_REGS = 16;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   // Register index holding the long-address-select bit
   localparam logic [3:0] CFG_REG_IDX = 4'he;
   localparam int LONG_ADDR_BIT = 3;
   // Upper address pair (remote start address lo/hi)
   localparam logic [3:0] RSA_LO_IDX = 4'h8;
   localparam logic [3:0] RSA_HI_IDX = 4'h9;
   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int ACK_DELAY_NS = 200;
   localparam int ACK_DELAY_CYC = (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] ACK_CNT_MAX = 2'(ACK_DELAY_CYC);
   // ************************************************
   // DMA cycle states
   // ************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4} hbs_dma_state_type;
endpackage : hbs_pkg

// ### logic/hbs_host_port.sv
/*
 Host bus slave register access, local DMA cycle sequencer and remote port handshake.
 Assumes all pin inputs except rst_n_i are asynchronous to ref_clk_i; each of those passes two flip-flops.
 The outside world resolves the data bus and the shared pin from the enables.
*/
// Summary of operation
// - Write strobe rising edge stores selected register
// - Read strobe low drives selected register
// - Acknowledge low only after synchronisation
// - DMA cycle is four clocks t1-t4
// - Sample READY at t3, wait while high
// - Each wait state adds one clock
// - Latch read done starts new read
// - Port latch write rises with valid data
// - Long mode: shared pin strobes upper address
// - Upper strobe floats until bus grant
// - Short mode: shared pin is port request
// - One request starts one remote transfer
// - Select lines latch on lower strobe fall
module hbs_host_port #(
   parameter int REG_SEL_W = hbs_pkg::REG_SEL_W,
   parameter int DATA_W = hbs_pkg::DATA_W
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Host slave access
   input wire logic dev_select_n_i,
   input wire logic lower_addr_strobe_i,
   input wire logic [REG_SEL_W-1:0] reg_select_lines_i,
   input wire logic host_write_strobe_n_i,
   input wire logic host_read_strobe_n_i,
   input wire logic [DATA_W-1:0] host_data_i,
   output logic [DATA_W-1:0] host_data_o,
   output logic host_data_oe_o,
   output logic access_ack_n_o,
   // Local DMA
   input wire logic ready_i,
   input wire logic bus_grant_i,
   input wire logic [DATA_W-1:0] local_data_i,
   output logic [DATA_W-1:0] local_data_o,
   output logic dma_active_o,
   // Remote port
   input wire logic latch_read_done_i,
   output logic port_latch_write_o,
   output logic port_req_strobe_o,
   output logic port_req_strobe_oe_o,
   output logic [DATA_W-1:0] upper_addr_o
);
   // ************************************************
   // Input synchronisers
   // ************************************************
   localparam int NSYNC = 7 + REG_SEL_W + DATA_W + DATA_W;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   // Reset to the idle pin levels so no false strobe edge follows reset
   // Order: select high, lower strobe low, write and read strobes high, rest low
   localparam logic [NSYNC-1:0] SYNC_IDLE = {4'hb, {(NSYNC-4){1'b0}}};
   wire [NSYNC-1:0] raw_in = {dev_select_n_i, lower_addr_strobe_i, host_write_strobe_n_i,
      host_read_strobe_n_i, ready_i, bus_grant_i, latch_read_done_i, reg_select_lines_i,
      host_data_i, local_data_i};
   // Two stages; only the second stage is read by logic
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         sync1_reg <= SYNC_IDLE;
         sync2_reg <= SYNC_IDLE;
      end
      else
      begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end
   wire cs_n_s = sync2_reg[NSYNC-1];
   wire lo_strobe_s = sync2_reg[NSYNC-2];
   wire wr_n_s = sync2_reg[NSYNC-3];
   wire rd_n_s = sync2_reg[NSYNC-4];
   wire ready_s = sync2_reg[NSYNC-5];
   wire grant_s = sync2_reg[NSYNC-6];
   wire read_done_s = sync2_reg[NSYNC-7];
   wire [REG_SEL_W-1:0] rsel_s = sync2_reg[2*DATA_W +: REG_SEL_W];
   wire [DATA_W-1:0] hdat_s = sync2_reg[DATA_W +: DATA_W];
   wire [DATA_W-1:0] ldat_s = sync2_reg[0 +: DATA_W];

   // ************************************************
   // Register select latch
   // ************************************************
   logic [REG_SEL_W-1:0] rsel_reg;
   logic wr_prev_reg;
   logic dma_busy;
   wire slave_ok = !cs_n_s && !dma_busy;
   // Flow through while strobe high, hold from its fall
   wire [REG_SEL_W-1:0] rsel_next = (slave_ok && lo_strobe_s) ? rsel_s : rsel_reg;
   wire [REG_SEL_W-1:0] rsel_eff = (slave_ok && lo_strobe_s) ? rsel_s : rsel_reg;
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         rsel_reg <= '0;
         wr_prev_reg <= 1'b1;
      end
      else
      begin
         rsel_reg <= rsel_next;
         wr_prev_reg <= wr_n_s;
      end
   end

   // ************************************************
   // Register file
   // ************************************************
   logic [DATA_W-1:0] regs_reg [hbs_pkg::NUM_REGS];
   // Host relies on select staying valid through data phase
   wire wr_rise = slave_ok && wr_n_s && !wr_prev_reg;
   genvar gi;
   generate
      for (gi = 0; gi < hbs_pkg::NUM_REGS; gi++)
      begin : g_reg
         always_ff @(posedge ref_clk_i)
         begin
            if (!rst_n_i)
               regs_reg[gi] <= hbs_pkg::REG_RESET_VAL;
            else if (wr_rise && rsel_eff == REG_SEL_W'(gi))
               regs_reg[gi] <= hdat_s;
         end
      end
   endgenerate
   wire long_mode = regs_reg[hbs_pkg::CFG_REG_IDX][hbs_pkg::LONG_ADDR_BIT];

   // ************************************************
   // Read data and acknowledge
   // ************************************************
   logic [1:0] ack_cnt_reg;
   wire strobe_on = slave_ok && (!wr_n_s || !rd_n_s);
   wire [1:0] ack_cnt_next = !strobe_on ? 2'h0 :
      (ack_cnt_reg == hbs_pkg::ACK_CNT_MAX) ? ack_cnt_reg : ack_cnt_reg + 2'h1;
   // Ack only after synchronised strobe has settled
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         ack_cnt_reg <= 2'h0;
         access_ack_n_o <= 1'b1;
         host_data_o <= '0;
         host_data_oe_o <= 1'b0;
      end
      else
      begin
         ack_cnt_reg <= ack_cnt_next;
         access_ack_n_o <= !(ack_cnt_next == hbs_pkg::ACK_CNT_MAX);
         host_data_o <= regs_reg[rsel_eff];
         host_data_oe_o <= slave_ok && !rd_n_s;
      end
   end

   // ************************************************
   // Remote request and DMA cycle sequencer
   // ************************************************
   hbs_pkg::hbs_dma_state_type st_reg;
   hbs_pkg::hbs_dma_state_type st_next;
   logic req_reg;
   logic done_prev_reg;
   logic refill_reg;
   wire done_rise = read_done_s && !done_prev_reg;
   assign dma_busy = (st_reg != hbs_pkg::ST_IDLE);
   // Grant active high starts the four-clock cycle
   wire start_cyc = (st_reg == hbs_pkg::ST_IDLE) && grant_s && (req_reg || refill_reg);
   always_comb
   begin
      st_next = st_reg;
      unique case (st_reg)
         hbs_pkg::ST_IDLE: if (start_cyc) st_next = hbs_pkg::ST_T1;
         hbs_pkg::ST_T1: st_next = hbs_pkg::ST_T2;
         hbs_pkg::ST_T2: st_next = hbs_pkg::ST_T3;
         hbs_pkg::ST_T3: st_next = ready_s ? hbs_pkg::ST_TW : hbs_pkg::ST_T4;
         hbs_pkg::ST_TW: st_next = ready_s ? hbs_pkg::ST_TW : hbs_pkg::ST_T4;
         hbs_pkg::ST_T4: st_next = hbs_pkg::ST_IDLE;
      endcase
   end
   wire cyc_done = (st_reg == hbs_pkg::ST_T4);
   // Request set once per transfer, cleared when the cycle finishes
   wire req_next = cyc_done ? 1'b0 : (st_reg == hbs_pkg::ST_IDLE && !req_reg) ? 1'b1 : req_reg;
   wire refill_next = done_rise ? 1'b1 : (start_cyc ? 1'b0 : refill_reg);
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         st_reg <= hbs_pkg::ST_IDLE;
         req_reg <= 1'b0;
         done_prev_reg <= 1'b0;
         refill_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         req_reg <= req_next;
         done_prev_reg <= read_done_s;
         refill_reg <= refill_next;
      end
   end

   // ************************************************
   // Port outputs
   // ************************************************
   // Strobe low in t2..tw, rising at t4 with data held valid
   wire latch_wr_next = (st_next == hbs_pkg::ST_T2 || st_next == hbs_pkg::ST_T3 || st_next == hbs_pkg::ST_TW);
   wire upper_strobe_next = (st_next == hbs_pkg::ST_T1);
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         port_latch_write_o <= 1'b1;
         port_req_strobe_o <= 1'b0;
         port_req_strobe_oe_o <= 1'b0;
         upper_addr_o <= '0;
         local_data_o <= '0;
         dma_active_o <= 1'b0;
      end
      else
      begin
         port_latch_write_o <= !latch_wr_next;
         if (st_reg == hbs_pkg::ST_T3)
            local_data_o <= ldat_s;
         port_req_strobe_o <= long_mode ? upper_strobe_next : req_next;
         port_req_strobe_oe_o <= long_mode ? grant_s : 1'b1;
         upper_addr_o <= (st_next == hbs_pkg::ST_T1) ? regs_reg[hbs_pkg::RSA_HI_IDX]
            : regs_reg[hbs_pkg::RSA_LO_IDX];
         dma_active_o <= (st_next != hbs_pkg::ST_IDLE);
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   sequence s_t3_ready_low;
      st_reg == hbs_pkg::ST_T3 && !ready_s;
   endsequence
   sequence s_t3_ready_high;
      st_reg == hbs_pkg::ST_T3 && ready_s;
   endsequence
   AST_T4_AFTER_T3: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_t3_ready_low |=> st_reg == hbs_pkg::ST_T4) else $error("t3 without wait not followed by t4");
   AST_WAIT_INSERT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_t3_ready_high |=> st_reg == hbs_pkg::ST_TW) else $error("wait state missing");
   AST_WAIT_ONE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_reg == hbs_pkg::ST_TW && !ready_s) |=> st_reg == hbs_pkg::ST_T4) else $error("wait too long");
   AST_FOUR_CLK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_reg == hbs_pkg::ST_T1) |=> st_reg == hbs_pkg::ST_T2 ##1 st_reg == hbs_pkg::ST_T3)
      else $error("cycle order wrong");
   AST_ACK_DELAY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $fell(access_ack_n_o) |-> $past(strobe_on, 2)) else $error("ack too early");
   AST_WR_STORE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_rise |=> regs_reg[$past(rsel_eff)] == $past(hdat_s)) else $error("write not stored");
   AST_RD_DRIVE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (slave_ok && !rd_n_s) |=> host_data_oe_o) else $error("read not driven");
   AST_REQ_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_reg && st_reg != hbs_pkg::ST_T4) |=> req_reg) else $error("request dropped early");
   AST_LATCH_WR_RISE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(port_latch_write_o) |-> st_reg == hbs_pkg::ST_T4) else $error("latch strobe rise misplaced");
   AST_UPPER_FLOAT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (long_mode && !grant_s) |=> !port_req_strobe_oe_o || $past(!long_mode)) else $error("strobe driven w/o grant");
   AST_REFILL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      done_rise |=> refill_reg || st_reg == hbs_pkg::ST_T1) else $error("refill not requested");

   // ************************************************
   // Further checks
   // ************************************************
   // Acknowledge and read path
   sequence s_ack_granted;
      !access_ack_n_o;
   endsequence
   sequence s_strobe_gone;
      !strobe_on;
   endsequence
   AST_ACK_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_ack_granted ##0 s_strobe_gone |=> access_ack_n_o) else $error("ack held after strobe release");
   AST_OE_READ_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !(slave_ok && !rd_n_s) |=> !host_data_oe_o) else $error("data driven without read");
   AST_RSEL_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (slave_ok && !lo_strobe_s) |=> rsel_reg == $past(rsel_reg)) else $error("select not held");
   // DMA sequencer
   AST_DMA_ACTIVE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_reg != hbs_pkg::ST_IDLE) |-> dma_active_o) else $error("active flag low in cycle");
   AST_FOUR_END: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_reg == hbs_pkg::ST_T4) |=> st_reg == hbs_pkg::ST_IDLE) else $error("t4 not last state");
   AST_GRANT_START: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_reg == hbs_pkg::ST_IDLE && !grant_s) |=> st_reg == hbs_pkg::ST_IDLE) else $error("cycle without grant");
   AST_LATCH_WR_LOW: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_reg == hbs_pkg::ST_T2) |-> !port_latch_write_o) else $error("latch strobe high in t2");
   AST_REFILL_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (refill_reg && start_cyc && !done_rise) |=> !refill_reg) else $error("refill not consumed");
   // Shared pin
   AST_UPPER_STROBE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_reg == hbs_pkg::ST_T1 && long_mode) |-> port_req_strobe_o) else $error("upper strobe missing");
   AST_REQ_GAP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (cyc_done && !long_mode) |=> !port_req_strobe_o) else $error("request not dropped");
   AST_SHORT_DRIVEN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !long_mode |=> port_req_strobe_oe_o) else $error("request pin floating");
endmodule : hbs_host_port

// ### dv/hbs_mem_model.sv
/*
 Buffer memory and system grant model facing the local DMA side.
 Assumes the bench sets grant, wait length and memory byte between cycles.
*/
module hbs_mem_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bench controls
   input wire logic grant_en_i,
   input wire logic [3:0] hold_i,
   input wire logic [7:0] mem_byte_i,
   // Local bus
   input wire logic dma_active_i,
   output logic bus_grant_o,
   output logic ready_o,
   output logic [7:0] local_data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_reg;
   logic act_reg;
   // Grant is active high, given only on bench request
   assign bus_grant_o = grant_en_i;
   // Ready raised as the cycle starts, so the synchronised copy is high by t3
   wire cyc_start = dma_active_i && !act_reg;
   assign ready_o = cyc_start ? (hold_i != 4'h0) : (wait_reg != 4'h0);
   // Data stable while granted, inverted otherwise so stale bytes never match
   assign local_data_o = grant_en_i ? mem_byte_i : ~mem_byte_i;
   always_ff @(posedge clk_i)
   begin
      act_reg <= dma_active_i;
      if (!rst_n_i)
         wait_reg <= 4'h0;
      else if (dma_active_i && !act_reg)
         wait_reg <= hold_i;
      else if (wait_reg != 4'h0)
         wait_reg <= wait_reg - 4'h1;
   end
endmodule : hbs_mem_model

// ### dv/tb_top.sv
/*
 Self-checking bench for the host port: register access, DMA timing, remote port.
 Assumes the design body keeps the hand-over contract; memory side is modelled.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, sel_n = 1, lo_strobe = 1, wr_n = 1, rd_n = 1, rdone = 0, gnt_en = 0;
   logic [3:0] rs = 4'h0, hold = 4'h0;
   logic [7:0] hdi = 8'h00, mbyte = 8'h00, lo_b, hi_b, hdo, ldo, ld, ua;
   logic oe, ack_n, rdy, gnt, act, latch_wr, req, req_oe, act_p, req_p, latch_wr_p, hi_seen;
   logic [7:0] exp_mem [16];
   int error_cnt = 0, tests_run = 0, run_len = 0, last_len = 0, dma_ends = 0, req_ends = 0;
   int latch_wr_cnt = 0, l1, i;
   logic latch_wr_act;
   logic [7:0] latch_wr_dat, v;
   always #50 clk = ~clk;
   hbs_host_port i_hbs_host_port (.ref_clk_i(clk), .rst_n_i(rst_n), .dev_select_n_i(sel_n),
      .lower_addr_strobe_i(lo_strobe), .reg_select_lines_i(rs), .host_write_strobe_n_i(wr_n),
      .host_read_strobe_n_i(rd_n), .host_data_i(hdi), .host_data_o(hdo), .host_data_oe_o(oe),
      .access_ack_n_o(ack_n), .ready_i(rdy), .bus_grant_i(gnt), .local_data_i(ld),
      .local_data_o(ldo), .dma_active_o(act), .latch_read_done_i(rdone),
      .port_latch_write_o(latch_wr), .port_req_strobe_o(req), .port_req_strobe_oe_o(req_oe),
      .upper_addr_o(ua));
   hbs_mem_model i_hbs_mem_model (.clk_i(clk), .rst_n_i(rst_n), .grant_en_i(gnt_en),
      .hold_i(hold), .mem_byte_i(mbyte), .dma_active_i(act), .bus_grant_o(gnt),
      .ready_o(rdy), .local_data_o(ld));
   // ***********************************
   // Tasks
   // ***********************************
   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task test_done;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task wait_ack(input logic lvl);
      int n;
      n = 0;
      while (ack_n !== lvl && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      check({7'h0, ack_n}, {7'h0, lvl});
   endtask : wait_ack
   // Select held low through data phase; host waits on acknowledge
   task reg_acc(input logic wr, input logic [3:0] idx, input logic [7:0] d);
      @(posedge clk);
      sel_n <= 1'b0;
      lo_strobe <= 1'b1;
      rs <= idx;
      hdi <= d;
      @(posedge clk);
      lo_strobe <= 1'b0;
      rs <= ~idx;
      @(posedge clk);
      if (wr) wr_n <= 1'b0;
      else rd_n <= 1'b0;
      @(posedge clk);
      #1 check({7'h0, ack_n}, 8'h01);
      wait_ack(1'b0);
      if (!wr) check(hdo, exp_mem[idx]);
      if (!wr) check({7'h0, oe}, 8'h01);
      @(posedge clk);
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      wait_ack(1'b1);
      @(posedge clk);
      sel_n <= 1'b1;
      if (wr) exp_mem[idx] = d;
   endtask : reg_acc
   task wait_end;
      int n, k;
      k = dma_ends;
      n = 0;
      while (dma_ends == k && n < 60)
      begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      #1 check(8'(n < 60), 8'h01);
   endtask : wait_end
   // Cycle length, latch write and request bookkeeping
   always @(posedge clk)
   begin
      act_p <= act;
      req_p <= req;
      latch_wr_p <= latch_wr;
      if (act) run_len <= run_len + 1;
      else if (run_len != 0)
      begin
         last_len <= run_len;
         run_len <= 0;
      end
      if (act_p && !act) dma_ends++;
      if (req_p && !req && req_oe) req_ends++;
      if (act && ua === hi_b) hi_seen <= 1'b1;
      if (latch_wr && !latch_wr_p)
      begin
         latch_wr_cnt++;
         latch_wr_act <= act;
         latch_wr_dat <= ldo;
      end
   end
   initial
   begin
      #(100 * 20000);
      error_cnt++;
      test_done();
   end
   // ***********************************
   // Main sequence
   // ***********************************
   initial
   begin
      void'($urandom(32'h09bd6eef));
      hi_seen = 1'b0;
      foreach (exp_mem[k]) exp_mem[k] = 8'h00;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check({7'h0, req_oe}, 8'h01);
      // Random register traffic, config register left clear
      for (i = 0; i < 10; i++)
      begin
         v = 8'($urandom);
         reg_acc(1'b1, 4'($urandom_range(0, 13)), v);
      end
      for (i = 0; i < 16; i++) reg_acc(1'b0, 4'(i), 8'h00);
      // Plain cycle, then stretched ones differing by three waits
      mbyte <= 8'($urandom);
      gnt_en <= 1'b1;
      wait_end();
      check(8'(last_len), 8'h04);
      hold <= 4'h5;
      wait_end();
      wait_end();
      l1 = last_len;
      hold <= 4'h8;
      wait_end();
      wait_end();
      check(8'(last_len), 8'(l1 + 3));
      check({7'h0, latch_wr_act}, 8'h01);
      check(latch_wr_dat, mbyte);
      gnt_en <= 1'b0;
      hold <= 4'h0;
      repeat (30) @(posedge clk);
      check(8'(req_ends), 8'(dma_ends));
      // Long address mode: strobe floats until grant
      lo_b = 8'($urandom);
      hi_b = ~lo_b;
      reg_acc(1'b1, hbs_pkg::RSA_LO_IDX, lo_b);
      reg_acc(1'b1, hbs_pkg::RSA_HI_IDX, hi_b);
      reg_acc(1'b1, hbs_pkg::CFG_REG_IDX, 8'h08);
      repeat (6) @(posedge clk);
      check({7'h0, req_oe}, 8'h00);
      check(ua, lo_b);
      hi_seen = 1'b0;
      mbyte <= 8'($urandom);
      gnt_en <= 1'b1;
      repeat (6) @(posedge clk);
      rdone <= 1'b1;
      repeat (3) @(posedge clk);
      rdone <= 1'b0;
      wait_end();
      check({7'h0, hi_seen}, 8'h01);
      check(latch_wr_dat, mbyte);
      gnt_en <= 1'b0;
      repeat (10) @(posedge clk);
      test_done();
   end
endmodule : tb_top
